// ---- verilog/photon_event_list_acquisition.sv ----
`timescale 1ns/100ps
// Operation
// - each event goes to the next sequential 16-bit word of the active buffer
// - event word has msb zero and 15 bits of location below
// - a list buffer is full after 32767 entries
// - timing word inserted every 4 to 512 ms, one entry each
// - timing word has msb one and 15-bit timing counter below
// - pulse amplitude is discarded during list acquisition
// - full or stopped buffer is sent as one 32k-word block
// - two buffers, one acquiring while the other is sent
// - block transfer runs at 1 Mbps, 32k words per block
// - fallback list mode entered after several successive software failures
// - fallback ignores software control until reset
module photon_event_list_acquisition #(
  parameter int STEP_CYC = event_list_pkg::HACK_STEP_CYC,
  parameter int BIT_CYC = event_list_pkg::BIT_CYC,
  parameter int FAIL_LIMIT = event_list_pkg::FAIL_LIMIT,
  parameter int FIFO_DEPTH = event_list_pkg::FIFO_DEPTH,
  parameter logic [event_list_pkg::HACK_SEL_W-1:0] DEFAULT_HACK_SEL = 8'h00
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic event_strobe_i,
  input wire event_list_pkg::event_s event_i,
  input wire event_list_pkg::acq_ctrl_s sw_ctrl_i,
  input wire logic sw_fail_i,
  input wire logic sw_ok_i,
  output logic fallback_o,
  output logic acquiring_o,
  output logic event_drop_o,
  output logic link_data_o,
  output logic link_gate_o,
  output logic link_block_start_o
);
  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_READ,
    TX_LOAD,
    TX_SHIFT
  } tx_e;

  typedef logic [event_list_pkg::HACK_SEL_W-1:0] sel_t;

  // selections above this would stretch the hack period past its maximum
  localparam int HACK_SEL_MAX =
      event_list_pkg::HACK_MAX_MS / event_list_pkg::HACK_MIN_MS - 1;

  typedef struct packed {
    logic [1:0] sync_strobe;
    event_list_pkg::event_s [1:0] sync_event;
    logic [1:0] strobe_q;
    logic running;
    logic fallback;
    logic [$clog2(FAIL_LIMIT+1)-1:0] fails;
    logic active;
    logic [1:0] full;
    logic [1:0][event_list_pkg::ADDR_W-1:0] fill;
    logic [event_list_pkg::ADDR_W-1:0] wr_addr;
    logic [event_list_pkg::HACK_SEL_W-1:0] hack_sel;
    logic [31:0] hack_cnt;
    logic hack_due;
    logic [event_list_pkg::TIME_CNT_W-1:0] time_cnt;
    logic [event_list_pkg::COORD_X_W-1:0] ev_x;
    logic [event_list_pkg::COORD_Y_W-1:0] ev_y;
    logic drop;
    tx_e tx;
    logic tx_buf;
    logic [event_list_pkg::ADDR_W:0] tx_idx;
    logic [event_list_pkg::WORD_W-1:0] shreg;
    logic [3:0] bit_idx;
    logic [15:0] bit_cnt;
    logic gate;
    logic sdata;
    logic blk_start;
  } state_s;

  state_s state;
  state_s next_state;

  logic [event_list_pkg::WORD_W-1:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [event_list_pkg::WORD_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  logic mem_we;
  logic [event_list_pkg::ADDR_W:0] mem_waddr;
  logic [event_list_pkg::ADDR_W:0] mem_raddr;
  logic [event_list_pkg::WORD_W-1:0] mem_rdata;
  logic [event_list_pkg::WORD_W-1:0] mem [2**(event_list_pkg::ADDR_W+1)];
  logic new_event;
  logic start_req;
  logic stop_req;
  logic [31:0] hack_period;

  function automatic logic [event_list_pkg::WORD_W-1:0] event_word(
    input logic [event_list_pkg::COORD_X_W-1:0] x,
    input logic [event_list_pkg::COORD_Y_W-1:0] y
  );
    logic [event_list_pkg::WORD_W-1:0] w;
    w = '0;
    w[event_list_pkg::WORD_W-1] = event_list_pkg::MARK_EVENT;
    w[event_list_pkg::X_LSB +: event_list_pkg::COORD_X_W] = x;
    w[event_list_pkg::Y_LSB +: event_list_pkg::COORD_Y_W] = y;
    return w;
  endfunction

  function automatic sel_t clamp_sel(input sel_t sel);
    if (32'(sel) > HACK_SEL_MAX) begin
      return sel_t'(HACK_SEL_MAX);
    end
    return sel;
  endfunction

  // -----------------------------------------------------------------
  // control decode
  // -----------------------------------------------------------------
  // software commands are masked out for good once fallback is taken
  assign start_req = sw_ctrl_i.start && !state.fallback;
  assign stop_req = sw_ctrl_i.stop && !state.fallback;
  assign new_event = state.strobe_q[0] && !state.strobe_q[1];
  // (sel+1) * 4 ms gives 4 .. 512 ms over sel 0..127
  assign hack_period = 32'((32'(state.hack_sel) + 32'd1) * 32'(STEP_CYC));

  // events and time hacks share the fifo; an event goes first and a due
  // hack waits a cycle, which is safe as events are never back to back
  always_comb begin
    fifo_in = '0;
    fifo_in_valid = 1'b0;
    if (state.running && new_event) begin
      // pulse amplitude never reaches the word
      fifo_in = event_word(state.ev_x, state.ev_y);
      fifo_in_valid = 1'b1;
    end else if (state.running && state.hack_due) begin
      fifo_in = {event_list_pkg::MARK_TIME, state.time_cnt};
      fifo_in_valid = 1'b1;
    end
  end

  assign mem_we = fifo_out_valid && !state.full[state.active];
  assign fifo_pop = mem_we;
  assign mem_waddr = {state.active, state.fill[state.active]};
  assign mem_raddr = {state.tx_buf, state.tx_idx[event_list_pkg::ADDR_W-1:0]};

  word_fifo #(
    .WIDTH(event_list_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .in_data_i(fifo_in),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop)
  );

  // -----------------------------------------------------------------
  // acquisition memory: two halves selected by top address bit
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (mem_we) begin
        mem[mem_waddr] <= fifo_out;
      end
      mem_rdata <= mem[mem_raddr];
    end
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.blk_start = 1'b0;
    next_state.sync_strobe = {state.sync_strobe[0], event_strobe_i};
    next_state.strobe_q = {state.strobe_q[0], state.sync_strobe[1]};
    next_state.sync_event = {state.sync_event[0], event_i};
    // the front end holds the location while its strobe is high, so the
    // synchronised strobe edge takes a settled copy
    if (state.sync_strobe[1] && !state.strobe_q[0]) begin
      next_state.ev_x = state.sync_event[1].x;
      next_state.ev_y = state.sync_event[1].y;
    end
    // overflow raises the drop flag in each cycle an entry is refused; an event is lost, a due hack stays pending
    next_state.drop = fifo_in_valid && !fifo_in_ready;

    if (sw_ok_i) begin
      next_state.fails = '0;
    end else if (sw_fail_i && !state.fallback) begin
      if (32'(state.fails) + 32'd1 >= 32'(FAIL_LIMIT)) begin
        next_state.fallback = 1'b1;
        next_state.running = 1'b1;
        next_state.hack_sel = clamp_sel(DEFAULT_HACK_SEL);
        next_state.time_cnt = '0;
        next_state.hack_cnt = '0;
      end else begin
        next_state.fails = state.fails + 1'b1;
      end
    end

    if (start_req && !state.running) begin
      next_state.running = 1'b1;
      next_state.hack_sel = clamp_sel(sw_ctrl_i.hack_sel);
      next_state.time_cnt = '0;
      next_state.hack_cnt = '0;
    end

    if (state.running) begin
      if (state.hack_due && fifo_in_ready && !new_event) begin
        next_state.hack_due = 1'b0;
        next_state.time_cnt = state.time_cnt + 1'b1;
      end
      if (state.hack_cnt + 32'd1 >= hack_period) begin
        next_state.hack_cnt = '0;
        next_state.hack_due = 1'b1;
      end else begin
        next_state.hack_cnt = state.hack_cnt + 32'd1;
      end
    end

    if (mem_we) begin
      if (32'(state.fill[state.active]) + 32'd1
          >= 32'(event_list_pkg::LIST_DEPTH)) begin
        next_state.full[state.active] = 1'b1;
        // the other half keeps its count until the sender has finished it
        next_state.active = !state.active;
      end
      next_state.fill[state.active] = state.fill[state.active] + 1'b1;
    end

    if (stop_req && state.running) begin
      next_state.running = 1'b0;
      next_state.hack_due = 1'b0;
      if (state.fill[state.active] != '0 && !state.full[state.active]) begin
        next_state.full[state.active] = 1'b1;
        next_state.active = !state.active;
      end
    end

    // block sender: 32k words msb first at the link bit rate
    case (state.tx)
      TX_IDLE: begin
        if (state.full[!state.active]) begin
          next_state.tx_buf = !state.active;
          next_state.tx_idx = '0;
          next_state.blk_start = 1'b1;
          next_state.tx = TX_READ;
        end
      end
      TX_READ: begin
        // the address stands now; the registered read lands at this edge
        next_state.tx = TX_LOAD;
      end
      TX_LOAD: begin
        next_state.tx = TX_SHIFT;
        next_state.bit_idx = 4'(event_list_pkg::WORD_W - 1);
        next_state.bit_cnt = '0;
        next_state.shreg = (state.tx_idx < {1'b0, state.fill[state.tx_buf]})
            ? mem_rdata : event_list_pkg::FILL_WORD;
        next_state.gate = 1'b1;
      end
      TX_SHIFT: begin
        next_state.sdata = state.shreg[state.bit_idx];
        if (32'(state.bit_cnt) + 32'd1 >= 32'(BIT_CYC)) begin
          next_state.bit_cnt = '0;
          if (state.bit_idx == '0) begin
            next_state.tx_idx = state.tx_idx + 1'b1;
            if (32'(state.tx_idx) + 32'd1
                >= 32'(event_list_pkg::BLOCK_WORDS)) begin
              next_state.full[state.tx_buf] = 1'b0;
              next_state.fill[state.tx_buf] = '0;
              next_state.gate = 1'b0;
              next_state.tx = TX_IDLE;
            end else begin
              // gate drops between words so the far side frames each one
              next_state.gate = 1'b0;
              next_state.tx = TX_READ;
            end
          end else begin
            next_state.bit_idx = state.bit_idx - 1'b1;
          end
        end else begin
          next_state.bit_cnt = state.bit_cnt + 1'b1;
        end
      end
      default: begin
        next_state.tx = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
      state.tx <= TX_IDLE;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  assign fallback_o = state.fallback;
  assign acquiring_o = state.running;
  assign event_drop_o = state.drop;
  assign link_data_o = state.sdata;
  assign link_gate_o = state.gate;
  assign link_block_start_o = state.blk_start;
endmodule

// ---- verilog/event_list_pkg.sv ----
package event_list_pkg;

  // -----------------------------------------------------------------
  // word format
  // -----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int COORD_X_W = 10;
  localparam int COORD_Y_W = 5;
  localparam int PULSE_W = 6;
  localparam int TIME_CNT_W = 15;
  localparam int X_LSB = 5;
  localparam int Y_LSB = 0;
  localparam logic MARK_EVENT = 1'b0;
  localparam logic MARK_TIME = 1'b1;

  // -----------------------------------------------------------------
  // buffer geometry
  // -----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int LIST_DEPTH = 32767;
  localparam int BLOCK_WORDS = 32768;
  localparam logic [WORD_W-1:0] FILL_WORD = 16'h0000;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int HACK_MIN_MS = 4;
  localparam int HACK_MAX_MS = 512;
  localparam int HACK_SEL_W = 8;
  // cycles per 4 ms step of the time hack period
  localparam int HACK_STEP_CYC = CLK_HZ / 1000 * HACK_MIN_MS;
  localparam int LINK_BPS = 1000000;
  localparam int BIT_CYC = CLK_HZ / LINK_BPS;
  localparam int FAIL_LIMIT = 3;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [COORD_X_W-1:0] x;
    logic [COORD_Y_W-1:0] y;
    logic [PULSE_W-1:0] pulse;
  } event_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic [HACK_SEL_W-1:0] hack_sel;
  } acq_ctrl_s;

endpackage

// ---- verilog/word_fifo.sv ----
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_s;

  ptr_s state;
  ptr_s next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (state.wr - state.rd) != DEPTH[AW:0];
  assign out_valid_o = state.wr != state.rd;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[state.rd[AW-1:0]];

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.wr = state.wr + 1'b1;
    end
    if (pop) begin
      next_state.rd = state.rd + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i && push) begin
      mem[state.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ---- test/photon_event_list_acquisition_chk.sv ----
`timescale 1ns/100ps
module photon_event_list_acquisition_chk #(
  parameter int BIT_CYC = 2,
  parameter int FAIL_LIMIT = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire event_list_pkg::acq_ctrl_s sw_ctrl_i,
  input wire logic sw_fail_i,
  input wire logic sw_ok_i,
  input wire logic fallback_o,
  input wire logic acquiring_o,
  input wire logic link_gate_o,
  input wire logic link_block_start_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // failures since the last good report, saturating at the limit
  int fails;
  int gate_run;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fails <= 0;
      gate_run <= 0;
    end else begin
      if (sw_ok_i) begin
        fails <= 0;
      end else if (sw_fail_i && fails < FAIL_LIMIT) begin
        fails <= fails + 1;
      end
      gate_run <= link_gate_o ? gate_run + 1 : 0;
    end
  end
  chk_fail_enter: assert property (
    fails == FAIL_LIMIT |-> ##[0:4] fallback_o)
    else $error("fallback missing after failures");
  chk_fail_cause: assert property (
    $rose(fallback_o) |-> fails == FAIL_LIMIT)
    else $error("fallback without enough failures");
  chk_fallback_held: assert property (
    fallback_o |=> fallback_o)
    else $error("fallback left without reset");
  chk_stop_ignored: assert property (
    fallback_o && acquiring_o |=> acquiring_o)
    else $error("acquisition halted in fallback");
  chk_start_ack: assert property (
    sw_ctrl_i.start && !sw_ctrl_i.stop && !acquiring_o && !fallback_o
    |=> acquiring_o)
    else $error("start not taken");
  chk_block_gate: assert property (
    link_block_start_o |-> ##[0:4] link_gate_o)
    else $error("block start without gate");
  chk_start_single: assert property (
    link_block_start_o |=> !link_block_start_o)
    else $error("block start longer than one cycle");
  chk_bit_rate: assert property (
    $fell(link_gate_o) && gate_run > 0 |-> gate_run == 16 * BIT_CYC)
    else $error("word gate length wrong");
endmodule

bind photon_event_list_acquisition photon_event_list_acquisition_chk #(
  .BIT_CYC(BIT_CYC),
  .FAIL_LIMIT(FAIL_LIMIT)
) u_photon_event_list_acquisition_chk (
  .sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .sw_ctrl_i(sw_ctrl_i),
  .sw_fail_i(sw_fail_i),
  .sw_ok_i(sw_ok_i),
  .fallback_o(fallback_o),
  .acquiring_o(acquiring_o),
  .link_gate_o(link_gate_o),
  .link_block_start_o(link_block_start_o)
);

// ---- test/link_sink.sv ----
`timescale 1ns/100ps
module link_sink #(
  parameter int BIT_CYC = 2
) (
  input wire logic sys_clk_i,
  input wire logic link_data_i,
  input wire logic link_gate_i,
  input wire logic block_start_i
);
  // only the head of a block is kept; a whole block outlasts the run
  logic [15:0] words [8];
  logic [15:0] shreg = 16'h0000;
  int n_words = 0;
  int cyc = 0;
  always @(posedge sys_clk_i) begin
    if (block_start_i) begin
      n_words <= 0;
    end
    if (!link_gate_i) begin
      cyc <= 0;
    end else begin
      cyc <= (cyc == 16 * BIT_CYC - 1) ? 0 : cyc + 1;
      // sample late in each bit time, msb first
      if (cyc % BIT_CYC == BIT_CYC - 1) begin
        shreg <= {shreg[14:0], link_data_i};
      end
      if (cyc == 16 * BIT_CYC - 1) begin
        if (n_words < 8) begin
          words[n_words] <= {shreg[14:0], link_data_i};
        end
        n_words <= n_words + 1;
      end
    end
  end
endmodule

// ---- test/tb_photon_event_list_acquisition.sv ----
`timescale 1ns/100ps
module tb_photon_event_list_acquisition;
  localparam int BIT_CYC = 2;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic event_strobe = 1'b0;
  logic sw_fail = 1'b0;
  logic sw_ok = 1'b0;
  event_list_pkg::event_s ev = '0;
  event_list_pkg::acq_ctrl_s sw_ctrl = '0;
  logic fallback, acquiring, link_data, link_gate, link_block_start;
  logic event_drop;
  logic drop_seen = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [15:0] exp_ev [3];

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (event_drop === 1'b1) begin
      drop_seen <= 1'b1;
    end
  end

  photon_event_list_acquisition #(
    .STEP_CYC(50),
    .BIT_CYC(BIT_CYC)
  ) u_photon_event_list_acquisition (
    .sys_clk_i(sys_clk),
    .reset_i(reset),
    .clk_en_i(1'b1),
    .event_strobe_i(event_strobe),
    .event_i(ev),
    .sw_ctrl_i(sw_ctrl),
    .sw_fail_i(sw_fail),
    .sw_ok_i(sw_ok),
    .fallback_o(fallback),
    .acquiring_o(acquiring),
    .event_drop_o(event_drop),
    .link_data_o(link_data),
    .link_gate_o(link_gate),
    .link_block_start_o(link_block_start)
  );

  link_sink #(.BIT_CYC(BIT_CYC)) u_link_sink (
    .sys_clk_i(sys_clk),
    .link_data_i(link_data),
    .link_gate_i(link_gate),
    .block_start_i(link_block_start)
  );

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // bits: start, stop, failure, good report; one cycle each
  task automatic ctrl(input logic [3:0] s);
    {sw_ctrl.start, sw_ctrl.stop, sw_fail, sw_ok} = s;
    tick();
    {sw_ctrl.start, sw_ctrl.stop, sw_fail, sw_ok} = 4'h0;
    tick();
  endtask

  task automatic send_event(input logic [9:0] x, input logic [4:0] y,
      input logic [5:0] p, input int k);
    exp_ev[k] = {1'b0, x, y};
    ev = '{x: x, y: y, pulse: p};
    event_strobe = 1'b1;
    repeat (5) tick();
    event_strobe = 1'b0;
    // a released bus does not keep its last value
    ev = ~ev;
    repeat (5) tick();
  endtask

  task automatic test_reset();
    repeat (2) tick();
    reset = 1'b0;
    tick();
    check("idle outputs", {10'h0, event_drop, fallback, acquiring, link_data,
      link_gate, link_block_start}, 16'h0000);
  endtask

  task automatic test_list();
    int e;
    int h;
    int i;
    logic [15:0] w;
    ctrl(4'h8);
    check("acquiring", {15'h0, acquiring}, 16'h0001);
    send_event(10'h3ff, 5'h00, 6'h3f, 0);
    send_event(10'h000, 5'h1f, 6'h2a, 1);
    send_event(10'h155, 5'h0a, 6'h15, 2);
    repeat (100) tick();
    ctrl(4'h4);
    for (i = 0; i < 100 && !link_gate; i++) tick();
    sw_ctrl.hack_sel = 8'h01;
    ctrl(4'h8);
    check("acquire while sending", {14'h0, acquiring, link_gate},
      16'h0003);
    for (i = 0; i < 600 && u_link_sink.n_words < 8; i++) tick();
    // second half runs with a 100-cycle hack period from a fresh count
    check("hack 0", u_photon_event_list_acquisition.mem[16'h8000],
      16'h8000);
    check("hack 1", u_photon_event_list_acquisition.mem[16'h8001],
      16'h8001);
    check("hack count", {1'b0, u_photon_event_list_acquisition.state.fill[1]},
      16'h0002);
    e = 0;
    h = 0;
    for (i = 0; i < 8; i++) begin
      w = u_link_sink.words[i];
      if (w[15]) begin
        check("time word", w, {1'b1, h[14:0]});
        h++;
      end else begin
        check("event word", w, e < 3 ? exp_ev[e] : 16'h0000);
        e++;
      end
    end
    check("time word count", {15'h0, h == 2 || h == 3}, 16'h0001);
    check("no drops", {15'h0, drop_seen}, 16'h0000);
  endtask

  task automatic test_fallback();
    ctrl(4'h2);
    ctrl(4'h2);
    ctrl(4'h1);
    ctrl(4'h2);
    ctrl(4'h2);
    check("fallback early", {15'h0, fallback}, 16'h0000);
    ctrl(4'h2);
    repeat (3) tick();
    check("fallback", {15'h0, fallback}, 16'h0001);
    ctrl(4'h4);
    repeat (2) tick();
    check("stop ignored", {14'h0, fallback, acquiring}, 16'h0003);
    reset = 1'b1;
    repeat (2) tick();
    reset = 1'b0;
    tick();
    check("fallback cleared", {15'h0, fallback}, 16'h0000);
  endtask

  initial begin
    test_reset();
    test_list();
    test_fallback();
    tally_and_finish();
  end
endmodule
